// File: logic/epo_port_ctrl.sv
// port ownership, power switch, test select and line state logic
//
// Overview of operation
// - test select zero is normal operation; 0001b to 0101b select a test mode
// - code 0101b forces the port enabled; 0110b to 1111b select nothing
// - ownership resets to 1, cleared when configure flag rises
// - ownership held at 1 while configure flag is 0
// - ownership 1 routes the port to companion; high speed side stays off
// - without power switches the power bit reads 1, always powered
// - with power switches the power bit drives the switch directly
// - unpowered port is nonfunctional and reports no status changes
// - overcurrent on a powered switchable port clears the power bit
// - line state shows positive line in bit 11, negative in bit 10
// - line state valid only while disabled and a device is connected
// - line state 11b is not low speed; field reads zero while unpowered
`timescale 1ns/1ps
`default_nettype none
`include "epo_regs.svh"

module epo_port_ctrl (
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire epo_pkg::epo_addr_t reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire epo_pkg::epo_word_t reg_wdata,
  output epo_pkg::epo_word_t     reg_rdata,
  input  wire logic              global_configure_flag,
  input  wire logic              power_switch_capable,
  input  wire logic              overcurrent_in,
  input  wire logic              dp_in,
  input  wire logic              dm_in,
  input  wire logic              port_enabled,
  input  wire logic              connect_status,
  input  wire logic              change_event_in,
  output logic                   power_switch_on,
  output logic                   companion_route,
  output logic                   hs_drive_en,
  output epo_pkg::epo_test_t     test_select_out,
  output logic                   force_enable,
  output logic                   status_report_en,
  output logic                   change_event_out,
  output logic                   line_state_valid,
  output logic                   low_speed_detect,
  output epo_pkg::epo_mode_t     port_mode
);

  import epo_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic      psc_hit;
  logic      psc_wr;
  logic      psc_rd;
  logic      cf_rise;
  epo_line_t lines_r;
  epo_test_t test_r;
  logic [1:0] rsvd_r;
  logic      owner_r;
  logic      power_r;
  logic      power_eff;
  logic      test_legal;
  epo_line_t line_field;
  epo_mode_t mode_nxt;
  epo_word_t rdata_nxt;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  // single mapped offset
  assign psc_hit = (reg_addr == `EPO_PSC_OFFSET);
  assign psc_wr  = reg_wr && psc_hit;
  assign psc_rd  = reg_rd && psc_hit;

  // ----------------------------------------------------------------
  // configure flag edge and line sampling
  // ----------------------------------------------------------------
  epo_rise_det #(
    .W (1)
  ) u_cf_rise (
    .core_clk (core_clk),
    .resetn   (resetn),
    .level_in (global_configure_flag),
    .rise_r   (cf_rise)
  );

  epo_line_sample #(
    .W (2)
  ) u_line (
    .core_clk (core_clk),
    .resetn   (resetn),
    .lines_in ({dp_in, dm_in}),
    .lines_r  (lines_r)
  );

  // ----------------------------------------------------------------
  // test select field
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      test_r <= `EPO_TEST_RST;
    end else if (psc_wr) begin
      test_r <= reg_wdata[`EPO_TEST_HI:`EPO_TEST_LO];
    end
  end

  // reserved codes are stored but select no test
  assign test_legal = (test_r != `EPO_TEST_NONE) && (test_r <= `EPO_TEST_LAST_VALID);

  // ----------------------------------------------------------------
  // reserved bits
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rsvd_r <= `EPO_RSVD_RST;
    end else if (psc_wr) begin
      rsvd_r <= reg_wdata[`EPO_RSVD_HI:`EPO_RSVD_LO];
    end
  end

  // ----------------------------------------------------------------
  // port ownership
  // ----------------------------------------------------------------
  // flag level and flag rise win over software
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      owner_r <= `EPO_OWNER_RST;
    end else if (!global_configure_flag) begin
      owner_r <= 1'b1;
    end else if (cf_rise) begin
      owner_r <= 1'b0;
    end else if (psc_wr) begin
      owner_r <= reg_wdata[`EPO_OWNER_BIT];
    end
  end

  // ----------------------------------------------------------------
  // port power
  // ----------------------------------------------------------------
  // overcurrent clear wins over a software write
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      power_r <= `EPO_POWER_RST;
    end else if (!power_switch_capable) begin
      power_r <= 1'b1;
    end else if (overcurrent_in && power_r) begin
      power_r <= 1'b0;
    end else if (psc_wr) begin
      power_r <= reg_wdata[`EPO_POWER_BIT];
    end
  end

  // without switches the port is powered from reset onward
  assign power_eff = power_switch_capable ? power_r : 1'b1;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      power_switch_on <= 1'b0;
    end else begin
      power_switch_on <= power_eff;
    end
  end

  // ----------------------------------------------------------------
  // line state field
  // ----------------------------------------------------------------
  // unpowered port shows zero here
  assign line_field = power_eff ? lines_r : `EPO_LINE_RST;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      line_state_valid <= 1'b0;
    end else begin
      line_state_valid <= power_eff && !port_enabled && connect_status;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      low_speed_detect <= 1'b0;
    end else begin
      // undefined code 11b counts as not low speed
      low_speed_detect <= power_eff && !port_enabled && connect_status
                          && (lines_r == `EPO_LINE_K);
    end
  end

  // ----------------------------------------------------------------
  // operating mode
  // ----------------------------------------------------------------
  always_comb begin
    mode_nxt = EPO_MODE_OFF;
    case ({power_eff, owner_r})
      2'b10: begin
        if (test_legal) begin
          mode_nxt = EPO_MODE_HS_TEST;
        end else begin
          mode_nxt = EPO_MODE_HS_NORMAL;
        end
      end
      2'b11: begin
        mode_nxt = EPO_MODE_COMPANION;
      end
      default: begin
        mode_nxt = EPO_MODE_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      port_mode <= EPO_MODE_COMPANION;
    end else begin
      port_mode <= mode_nxt;
    end
  end

  // ----------------------------------------------------------------
  // routing and test outputs
  // ----------------------------------------------------------------
  // companion owns the port while ownership is 1
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      companion_route <= 1'b1;
    end else begin
      companion_route <= owner_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      hs_drive_en <= 1'b0;
    end else begin
      hs_drive_en <= !owner_r && power_eff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      test_select_out <= `EPO_TEST_NONE;
    end else if (mode_nxt == EPO_MODE_HS_TEST) begin
      test_select_out <= test_r;
    end else begin
      test_select_out <= `EPO_TEST_NONE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      force_enable <= 1'b0;
    end else begin
      force_enable <= (mode_nxt == EPO_MODE_HS_TEST) && (test_r == `EPO_TEST_FORCE_EN);
    end
  end

  // ----------------------------------------------------------------
  // status change gating
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      status_report_en <= 1'b0;
    end else begin
      status_report_en <= power_eff;
    end
  end

  // events dropped while unpowered
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      change_event_out <= 1'b0;
    end else begin
      change_event_out <= change_event_in && power_eff;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = `EPO_WORD_ZERO;
    rdata_nxt[`EPO_TEST_HI:`EPO_TEST_LO] = test_r;
    rdata_nxt[`EPO_RSVD_HI:`EPO_RSVD_LO] = rsvd_r;
    rdata_nxt[`EPO_OWNER_BIT]            = owner_r;
    rdata_nxt[`EPO_POWER_BIT]            = power_eff;
    rdata_nxt[`EPO_LINE_HI:`EPO_LINE_LO] = line_field;
  end

  // unmapped offsets and idle cycles read zero
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      reg_rdata <= `EPO_WORD_ZERO;
    end else if (psc_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= `EPO_WORD_ZERO;
    end
  end

endmodule

`default_nettype wire

// File: logic/epo_regs.svh
// register offsets, field positions, reset values and codes of the port block
`ifndef EPO_REGS_SVH
`define EPO_REGS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define EPO_ADDR_W           8
`define EPO_PSC_OFFSET       8'h64

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EPO_TEST_HI          19
`define EPO_TEST_LO          16
`define EPO_RSVD_HI          15
`define EPO_RSVD_LO          14
`define EPO_OWNER_BIT        13
`define EPO_POWER_BIT        12
`define EPO_LINE_HI          11
`define EPO_LINE_LO          10
`define EPO_LINE_DP_BIT      11
`define EPO_LINE_DM_BIT      10

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EPO_TEST_RST         4'h0
`define EPO_RSVD_RST         2'h0
`define EPO_OWNER_RST        1'h1
`define EPO_POWER_RST        1'h0
`define EPO_LINE_RST         2'h0
`define EPO_WORD_ZERO        32'h00000000

// ----------------------------------------------------------------
// test select codes
// ----------------------------------------------------------------
`define EPO_TEST_NONE        4'h0
`define EPO_TEST_LAST_VALID  4'h5
`define EPO_TEST_FORCE_EN    4'h5

// ----------------------------------------------------------------
// line state codes
// ----------------------------------------------------------------
`define EPO_LINE_SE0         2'h0
`define EPO_LINE_K           2'h1
`define EPO_LINE_J           2'h2
`define EPO_LINE_UNDEF       2'h3

`endif

// File: logic/epo_pkg.sv
// types shared by the port ownership and power block
`default_nettype none

package epo_pkg;

  // ----------------------------------------------------------------
  // data types
  // ----------------------------------------------------------------
  typedef logic [31:0] epo_word_t;
  typedef logic [7:0]  epo_addr_t;
  typedef logic [3:0]  epo_test_t;
  typedef logic [1:0]  epo_line_t;

  // ----------------------------------------------------------------
  // port operating mode
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    EPO_MODE_OFF,
    EPO_MODE_COMPANION,
    EPO_MODE_HS_NORMAL,
    EPO_MODE_HS_TEST
  } epo_mode_t;

endpackage

`default_nettype wire

// File: logic/epo_rise_det.sv
// registered rising edge detector for a group of levels
`timescale 1ns/1ps
`default_nettype none

module epo_rise_det #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] level_in,
  output logic      [W-1:0] rise_r
);

  // ----------------------------------------------------------------
  // previous level and edge pulse
  // ----------------------------------------------------------------
  logic [W-1:0] prev_r;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      prev_r <= '0;
    end else begin
      prev_r <= level_in;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rise_r <= '0;
    end else begin
      rise_r <= level_in & ~prev_r;
    end
  end

endmodule

`default_nettype wire

// File: logic/epo_line_sample.sv
// sampling register for the data line levels
`timescale 1ns/1ps
`default_nettype none

module epo_line_sample #(
  parameter int W = 2
) (
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] lines_in,
  output logic      [W-1:0] lines_r
);

  // ----------------------------------------------------------------
  // sample every clock
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      lines_r <= '0;
    end else begin
      lines_r <= lines_in;
    end
  end

endmodule

`default_nettype wire

// File: verification/epo_usb_dev_model.sv
// attached usb device model driving data lines and connect status
`timescale 1ns/1ps
`default_nettype none

module epo_usb_dev_model (
  input  wire logic               attach,
  input  wire epo_pkg::epo_line_t line_code,
  output logic                    dp_out,
  output logic                    dm_out,
  output logic                    connect_out
);
  import epo_pkg::*;
  // detached lines fall to se0 through host pull-downs
  assign dp_out = attach & line_code[1];
  assign dm_out = attach & line_code[0];
  assign connect_out = attach;
endmodule
`default_nettype wire

// File: verification/epo_port_ctrl_sva.sv
// assertions on the ports of the port ownership and power block
`timescale 1ns/1ps
`default_nettype none
`include "epo_regs.svh"

module epo_port_ctrl_sva (
  input wire logic               core_clk,
  input wire logic               resetn,
  input wire epo_pkg::epo_addr_t reg_addr,
  input wire logic               reg_wr,
  input wire epo_pkg::epo_word_t reg_wdata,
  input wire logic               global_configure_flag,
  input wire logic               power_switch_capable,
  input wire logic               overcurrent_in,
  input wire logic               dp_in,
  input wire logic               port_enabled,
  input wire logic               connect_status,
  input wire logic               change_event_in,
  input wire logic               power_switch_on,
  input wire logic               companion_route,
  input wire logic               hs_drive_en,
  input wire epo_pkg::epo_test_t test_select_out,
  input wire logic               force_enable,
  input wire logic               status_report_en,
  input wire logic               change_event_out,
  input wire logic               line_state_valid,
  input wire logic               low_speed_detect
);
  import epo_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic wr_hit;
  assign wr_hit = reg_wr && (reg_addr == `EPO_PSC_OFFSET);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_owner_hold: assert property (!global_configure_flag |-> ##2 companion_route)
    else $error("owner not held while flag low");
  a_owner_clear: assert property (
    $rose(global_configure_flag) && $past(resetn) ##1 global_configure_flag [*2] |=> !companion_route)
    else $error("owner not cleared on flag rise");
  a_route_excl: assert property (companion_route |-> !hs_drive_en)
    else $error("high speed drive while companion owns");
  a_comp_no_test: assert property (companion_route |-> test_select_out == `EPO_TEST_NONE)
    else $error("test select while companion owns");
  a_nosw_power: assert property (!power_switch_capable [*3] |-> status_report_en)
    else $error("port unpowered without switches");
  a_power_write: assert property (
    power_switch_capable && !overcurrent_in && wr_hit ##1 power_switch_capable && !overcurrent_in
    && !reg_wr |=> power_switch_on == $past(reg_wdata[`EPO_POWER_BIT], 2))
    else $error("power switch not following power bit");
  a_oc_cut: assert property (
    power_switch_capable && overcurrent_in && power_switch_on && !reg_wr |-> ##2 !power_switch_on)
    else $error("power not cut on overcurrent");
  a_quiet_off: assert property (change_event_in |=> change_event_out == status_report_en)
    else $error("change event not gated by power");
  a_line_valid: assert property (
    port_enabled || !connect_status |=> !line_state_valid && !low_speed_detect)
    else $error("line state valid outside condition");
  a_ls_not_k: assert property (dp_in [*3] |-> !low_speed_detect)
    else $error("low speed with positive line high");
  a_force_code: assert property (force_enable |-> test_select_out == `EPO_TEST_FORCE_EN)
    else $error("force enable without its code");
  c_flag_rise: cover property ($rose(global_configure_flag));
  c_oc_cut: cover property (overcurrent_in && power_switch_on);
  c_low_speed: cover property (low_speed_detect);
endmodule

bind epo_port_ctrl epo_port_ctrl_sva u_epo_port_ctrl_sva (
  .core_clk, .resetn, .reg_addr, .reg_wr, .reg_wdata, .global_configure_flag,
  .power_switch_capable, .overcurrent_in, .dp_in, .port_enabled, .connect_status,
  .change_event_in, .power_switch_on, .companion_route, .hs_drive_en, .test_select_out,
  .force_enable, .status_report_en, .change_event_out, .line_state_valid, .low_speed_detect
);
`default_nettype wire

// File: verification/test_epo_port_ctrl.sv
// self-checking bench of the port ownership and power block
`timescale 1ns/1ps
`default_nettype none
`include "epo_regs.svh"

module test_epo_port_ctrl;
  import epo_pkg::*;
  logic core_clk = 1'h0, resetn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic global_configure_flag = 1'h0, power_switch_capable = 1'h1, overcurrent_in = 1'h0;
  logic port_enabled = 1'h0, change_event_in = 1'h0, attach = 1'h0;
  logic dp_in, dm_in, connect_status, power_switch_on, companion_route, hs_drive_en;
  logic force_enable, status_report_en, change_event_out, line_state_valid, low_speed_detect;
  epo_addr_t reg_addr = 8'h00;
  epo_word_t reg_wdata = 32'h0, reg_rdata, rdata, seed = 32'hFB87;
  epo_line_t line_code = 2'h0;
  epo_test_t test_select_out;
  epo_mode_t port_mode;
  int        num_errors = 0, cmp_count = 0, cycles = 0;

  epo_port_ctrl u_epo_port_ctrl (
    .core_clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .global_configure_flag, .power_switch_capable, .overcurrent_in, .dp_in, .dm_in,
    .port_enabled, .connect_status, .change_event_in, .power_switch_on, .companion_route,
    .hs_drive_en, .test_select_out, .force_enable, .status_report_en, .change_event_out,
    .line_state_valid, .low_speed_detect, .port_mode);
  epo_usb_dev_model u_epo_usb_dev_model (
    .attach, .line_code, .dp_out(dp_in), .dm_out(dm_in), .connect_out(connect_status));

  // ----------------------------------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------------------------------
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      finish_test();
    end
  end
  function automatic epo_word_t lfsr(epo_word_t x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic epo_word_t word(epo_test_t t, logic o, logic p, epo_line_t l);
    return {12'h000, t, `EPO_RSVD_RST, o, p, l, 10'h000};
  endfunction
  task automatic check(input epo_word_t seen, input epo_word_t exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input epo_word_t d);
    @(negedge core_clk);
    reg_addr = `EPO_PSC_OFFSET;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge core_clk);
    reg_wr = 1'h0;
  endtask
  task automatic rd(input epo_addr_t a, output epo_word_t d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge core_clk);
    reg_rd = 1'h0;
    d = reg_rdata;
  endtask
  task automatic finish_test();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    cyc(12);
    resetn = 1'h1;
    rd(`EPO_PSC_OFFSET, rdata);
    check(rdata, word(4'h0, 1'h1, 1'h0, 2'h0));
    rd(8'h60, rdata);
    check(rdata, 32'h0);
    wr(word(4'h0, 1'h0, 1'h0, 2'h0));
    rd(`EPO_PSC_OFFSET, rdata);
    check(rdata[`EPO_OWNER_BIT], 1'h1);
    global_configure_flag = 1'h1;
    cyc(4);
    check(companion_route, 1'h0);
    wr(word(4'h0, 1'h0, 1'h1, 2'h0));
    cyc(2);
    check({hs_drive_en, power_switch_on}, 2'h3);
    for (int c = 0; c < 16; c++) begin
      wr(word(c[3:0], 1'h0, 1'h1, 2'h0));
      cyc(2);
      check(test_select_out, (c <= 5) ? c[3:0] : 4'h0);
      check(force_enable, c == 5);
      check(port_mode, (c == 0 || c > 5) ? EPO_MODE_HS_NORMAL : EPO_MODE_HS_TEST);
      rd(`EPO_PSC_OFFSET, rdata);
      check(rdata, word(c[3:0], 1'h0, 1'h1, 2'h0));
    end
    wr(word(4'h0, 1'h0, 1'h1, 2'h0));
    attach = 1'h1;
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      line_code = (i < 4) ? i[1:0] : seed[1:0];
      cyc(3);
      rd(`EPO_PSC_OFFSET, rdata);
      check(rdata[11:10], line_code);
      check(low_speed_detect, line_code == `EPO_LINE_K);
      check(line_state_valid, 1'h1);
      if (line_code == `EPO_LINE_K) begin
        wr(word(4'h0, 1'h1, 1'h1, 2'h0));
        cyc(2);
        check({companion_route, hs_drive_en}, 2'h2);
        check(port_mode, EPO_MODE_COMPANION);
        wr(word(4'h0, 1'h0, 1'h1, 2'h0));
      end
    end
    port_enabled = 1'h1;
    cyc(2);
    check(line_state_valid, 1'h0);
    port_enabled = 1'h0;
    for (int p = 1; p >= 0; p--) begin
      wr(word(4'h0, 1'h0, p[0], 2'h0));
      cyc(2);
      change_event_in = 1'h1;
      cyc(1);
      change_event_in = 1'h0;
      check({change_event_out, status_report_en, hs_drive_en}, {3{p[0]}});
      check(port_mode, p[0] ? EPO_MODE_HS_NORMAL : EPO_MODE_OFF);
    end
    wr(word(4'h0, 1'h0, 1'h1, 2'h0));
    cyc(2);
    overcurrent_in = 1'h1;
    wr(word(4'h0, 1'h0, 1'h1, 2'h0));
    cyc(2);
    rd(`EPO_PSC_OFFSET, rdata);
    check(rdata, word(4'h0, 1'h0, 1'h0, 2'h0));
    check(power_switch_on, 1'h0);
    overcurrent_in = 1'h0;
    power_switch_capable = 1'h0;
    cyc(4);
    rd(`EPO_PSC_OFFSET, rdata);
    check(rdata, word(4'h0, 1'h0, 1'h1, line_code));
    check(status_report_en, 1'h1);
    power_switch_capable = 1'h1;
    global_configure_flag = 1'h0;
    cyc(3);
    check({companion_route, hs_drive_en}, 2'h2);
    resetn = 1'h0;
    cyc(2);
    resetn = 1'h1;
    rd(`EPO_PSC_OFFSET, rdata);
    check(rdata, word(4'h0, 1'h1, 1'h0, 2'h0));
    check({companion_route, hs_drive_en, power_switch_on}, 3'h4);
    finish_test();
  end
endmodule
`default_nettype wire
